/* csc_params.svh */
// Purpose: constants of the card supply class selector
// Assumes: included by its bare name
// Notes: byte values are answer-to-reset characters
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

// ==========================================================
// answer-to-reset characters
`define CSC_TS_BYTE 8'h3B
`define CSC_T0_Y 4'h8
`define CSC_TD1_BYTE 8'h80
`define CSC_TD2_BYTE 8'h3F
`define CSC_GLOBAL_PROTO 4'hF

// ==========================================================
// byte positions in the answer
`define CSC_IDX_TS 5'h00
`define CSC_IDX_T0 5'h01
`define CSC_IDX_TD1 5'h02
`define CSC_IDX_TD2 5'h03
`define CSC_IDX_TA3 5'h04
`define CSC_IDX_TB3 5'h05
`define CSC_HIST_BASE 5'h06

// ==========================================================
// class indication byte layout
`define CSC_CLASS_W 5
`define CSC_CLASS_A_BIT 0
`define CSC_CLASS_B_BIT 1
`define CSC_CLASS_C_BIT 2
`define CSC_CLASS_D_BIT 3
`define CSC_CLASS_E_BIT 4
`define CSC_CLKSTOP_LSB 6

// ==========================================================
// reset values
`define CSC_DATA_RST 8'h00
`define CSC_TCK_RST 8'h00
`define CSC_IDX_RST 5'h00

`endif

/* csc_pkg.sv */
// Purpose: types of the card supply class selector
// Assumes: nothing
// Notes: state codes written out
package csc_pkg;

   typedef enum logic [1:0] {
      CSC_S_HOLD = 2'b00,
      CSC_S_ATR = 2'b01,
      CSC_S_RUN = 2'b10
   } csc_state_type;

   typedef struct packed {
      csc_state_type state;
      logic [4:0] idx;
      logic [7:0] data;
      logic full;
      logic [7:0] tck;
      logic app_active;
      logic app_sel;
   } csc_regs_type;

endpackage

/* csc_class_enc.sv */
// Purpose: builds the class indication byte
// Assumes: class_support may hold any pattern
// Notes: keeps only the lowest contiguous run of classes
`timescale 1ns/100ps
`include "csc_params.svh"

module csc_class_enc #(
   parameter int CLASS_W = `CSC_CLASS_W
) (
   input wire logic [CLASS_W-1:0] class_support,
   input wire logic [1:0] clk_stop_ind,
   output logic [7:0] class_byte,
   output logic class_trimmed
);
   import csc_pkg::*;

   logic [CLASS_W-1:0] run;
   logic in_run;
   logic stopped;

   // ==========================================================
   // lowest run of adjacent classes only
   always_comb begin
      run = '0;
      in_run = 1'b0;
      stopped = 1'b0;
      for (int i = 0; i < CLASS_W; i++) begin
         if (class_support[i] && !stopped) begin
            run[i] = 1'b1;
            in_run = 1'b1;
         end else if (in_run) begin
            stopped = 1'b1;
         end
      end
   end

   always_comb begin
      class_byte = 8'h00;
      class_byte[CLASS_W-1:0] = run;
      class_byte[`CSC_CLKSTOP_LSB +: 2] = clk_stop_ind;
   end

   assign class_trimmed = (run != class_support);

endmodule

/* csc_card_core.sv */
// Purpose: card side of supply class negotiation and answer-to-reset
// Assumes: all inputs but the asynchronous reset arst_n synchronous to core_clk; card_rst_n is the card reset line
// Notes: answer is TS T0 TD1 TD2 TA3 TB3 hist TCK, then responses pass
`timescale 1ns/100ps
`include "csc_params.svh"

module csc_card_core #(
   parameter int HIST_LEN = 4,
   parameter int CLASS_W = `CSC_CLASS_W
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic card_rst_n,
   input wire logic [CLASS_W-1:0] class_support,
   input wire logic [1:0] clk_stop_ind,
   input wire logic [7:0] global_tb,
   output logic [3:0] hist_addr,
   input wire logic [7:0] hist_byte,
   output logic [7:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   input wire logic [7:0] resp_data,
   input wire logic resp_valid,
   output logic resp_ready,
   output logic atr_done,
   output logic class_trimmed,
   input wire logic app_select,
   input wire logic ac_required,
   input wire logic ac_verified,
   input wire logic cmd_done,
   input wire logic cmd_is_app,
   input wire logic cmd_is_status,
   output logic app_selected
);
   import csc_pkg::*;

   localparam logic [4:0] TCK_IDX = 5'(`CSC_HIST_BASE + HIST_LEN);
   localparam csc_regs_type REGS_RST = '{
      state: CSC_S_HOLD, idx: `CSC_IDX_RST, data: `CSC_DATA_RST, full: 1'b0,
      tck: `CSC_TCK_RST, app_active: 1'b0, app_sel: 1'b0};

   csc_regs_type regs_reg;
   csc_regs_type regs_next;
   logic [7:0] class_byte;
   logic [4:0] idx_inc;
   logic app_cmd_hit;

   csc_class_enc #(.CLASS_W(CLASS_W)) u_class (
      .class_support(class_support),
      .clk_stop_ind(clk_stop_ind),
      .class_byte(class_byte),
      .class_trimmed(class_trimmed)
   );

   // ==========================================================
   // outputs
   assign out_data = regs_reg.data;
   assign out_valid = (regs_reg.state == CSC_S_ATR) || 
                      ((regs_reg.state == CSC_S_RUN) && regs_reg.full);
   // nothing else leaves the card until the answer is out
   assign resp_ready = (regs_reg.state == CSC_S_RUN) && (!regs_reg.full || out_ready);
   assign atr_done = (regs_reg.state == CSC_S_RUN);
   assign app_selected = regs_reg.app_sel;
   assign hist_addr = 4'(regs_reg.idx - (`CSC_HIST_BASE - 5'h01));
   assign idx_inc = regs_reg.idx + 5'h01;
   // a STATUS after select does not count as an application command
   assign app_cmd_hit = cmd_done && cmd_is_app && !cmd_is_status && !ac_required;

   // ==========================================================
   // next state
   always_comb begin
      regs_next = regs_reg;
      case (regs_reg.state)
         CSC_S_HOLD: begin
            if (card_rst_n) begin
               regs_next.state = CSC_S_ATR;
               regs_next.idx = `CSC_IDX_TS;
               regs_next.data = `CSC_TS_BYTE;
               regs_next.tck = `CSC_TCK_RST;
            end
         end
         CSC_S_ATR: begin
            if (out_ready) begin
               regs_next.idx = idx_inc;
               if (regs_reg.idx != `CSC_IDX_TS) begin
                  regs_next.tck = regs_reg.tck ^ regs_reg.data;
               end
               if (regs_reg.idx == TCK_IDX) begin
                  regs_next.state = CSC_S_RUN;
                  regs_next.full = 1'b0;
               end else if (idx_inc == `CSC_IDX_T0) begin
                  regs_next.data = {`CSC_T0_Y, 4'(HIST_LEN)};
               end else if (idx_inc == `CSC_IDX_TD1) begin
                  regs_next.data = `CSC_TD1_BYTE;
               end else if (idx_inc == `CSC_IDX_TD2) begin
                  regs_next.data = `CSC_TD2_BYTE;
               end else if (idx_inc == `CSC_IDX_TA3) begin
                  regs_next.data = class_byte;
               end else if (idx_inc == `CSC_IDX_TB3) begin
                  regs_next.data = global_tb;
               end else if (idx_inc == TCK_IDX) begin
                  regs_next.data = regs_reg.tck ^ regs_reg.data;
               end else begin
                  regs_next.data = hist_byte;
               end
            end
         end
         CSC_S_RUN: begin
            if (out_ready) begin
               regs_next.full = 1'b0;
            end
            if (resp_valid && resp_ready) begin
               regs_next.data = resp_data;
               regs_next.full = 1'b1;
            end
            // a new select starts afresh; otherwise verify or command selects
            if (app_select) begin
               regs_next.app_active = 1'b1;
               regs_next.app_sel = 1'b0;
            end else if (regs_reg.app_active && (ac_verified || app_cmd_hit)) begin
               regs_next.app_sel = 1'b1;
            end
         end
         default: begin
            regs_next = REGS_RST;
         end
      endcase
      if (!card_rst_n) begin
         regs_next.state = CSC_S_HOLD;
         regs_next.full = 1'b0;
         regs_next.app_active = 1'b0;
         regs_next.app_sel = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         regs_reg <= REGS_RST;
      end else begin
         regs_reg <= regs_next;
      end
   end

   // ==========================================================
   // assertions
   logic [5:0] run6;
   assign run6 = {1'b0, class_byte[4:0]};

   property p_first_ts;
      @(posedge core_clk) disable iff (!arst_n)
         (regs_reg.state == CSC_S_HOLD) && card_rst_n |=> out_valid && (out_data == 8'h3B);
   endproperty
   a_first_ts: assert property (p_first_ts) else $error("answer does not open with TS");

   property p_no_resp_early;
      @(posedge core_clk) disable iff (!arst_n)
         !atr_done |-> !resp_ready;
   endproperty
   a_no_resp_early: assert property (p_no_resp_early) else $error("response before answer");

   property p_td2_global;
      @(posedge core_clk) disable iff (!arst_n)
         (regs_reg.state == CSC_S_ATR) && (regs_reg.idx == `CSC_IDX_TD2) |->
            (out_data[3:0] == `CSC_GLOBAL_PROTO) && out_data[4];
   endproperty
   a_td2_global: assert property (p_td2_global) else $error("TD2 not T=15 with TA3");

   property p_ta3_class;
      @(posedge core_clk) disable iff (!arst_n)
         (regs_reg.state == CSC_S_ATR) && (regs_reg.idx == `CSC_IDX_TD2) && out_ready |=>
            (out_data[4:0] != 5'h00 || class_support == '0) &&
            (out_data[7:5] == {clk_stop_ind[1:0], 1'b0});
   endproperty
   a_ta3_class: assert property (p_ta3_class) else $error("TA3 class byte wrong");

   property p_class_bits;
      @(posedge core_clk) disable iff (!arst_n)
         class_support[0] |-> class_byte[0];
   endproperty
   a_class_bits: assert property (p_class_bits) else $error("class A bit lost");

   property p_contig;
      @(posedge core_clk) disable iff (!arst_n)
         (((run6 | (run6 - 6'h01)) + 6'h01) & run6) == 6'h00;
   endproperty
   a_contig: assert property (p_contig) else $error("classes not contiguous");

   property p_status_only;
      @(posedge core_clk) disable iff (!arst_n)
         atr_done && card_rst_n && app_select
            ##1 (!ac_verified && !(cmd_done && !cmd_is_status)) [*2] |=> !app_selected;
   endproperty
   a_status_only: assert property (p_status_only) else $error("STATUS selected app");

   property p_sel_set;
      @(posedge core_clk) disable iff (!arst_n)
         atr_done && card_rst_n && regs_reg.app_active && !app_select &&
            (ac_verified || (cmd_done && cmd_is_app && !cmd_is_status && !ac_required))
            |=> app_selected;
   endproperty
   a_sel_set: assert property (p_sel_set) else $error("application not selected");

   property p_tck_end;
      @(posedge core_clk) disable iff (!arst_n)
         (regs_reg.state == CSC_S_ATR) && (regs_reg.idx == TCK_IDX) |->
            ((regs_reg.tck ^ regs_reg.data) == 8'h00);
   endproperty
   a_tck_end: assert property (p_tck_end) else $error("check byte wrong");

   c_atr_done: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(atr_done));
   c_trim: cover property (@(posedge core_clk) disable iff (!arst_n) atr_done && class_trimmed);
   c_sel: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(app_selected));
   c_resp: cover property (@(posedge core_clk) disable iff (!arst_n)
      atr_done && out_valid && out_ready);

endmodule

/* csc_term_model.sv */
// Purpose: terminal side that takes the card's bytes and picks a supply class
// Assumes: driven from the card's byte port, core_clk domain
// Notes: slow makes the terminal accept only every fourth cycle
`timescale 1ns/100ps

module csc_term_model (
   input wire logic core_clk,
   input wire logic slow,
   input wire logic [7:0] out_data,
   input wire logic out_valid,
   output logic out_ready
);
   logic [7:0] got [$];
   logic [1:0] cnt = 2'h0;

   // takes every byte, known fields or not
   always @(posedge core_clk) begin
      if (out_valid && out_ready) begin
         got.push_back(out_data);
      end
      cnt <= cnt + 2'h1;
      out_ready <= #1 !slow || (cnt == 2'h3);
   end

   // ==========================================================
   // class choice from the class indication byte
   function automatic logic [4:0] pick(input logic [7:0] ta);
      pick = 5'h04;
      if (ta[2] == 1'b0) begin
         pick = ta[1] ? 5'h02 : 5'h01;
      end
   endfunction

   // ==========================================================
   // answer intact when all bytes after the first xor to zero
   function automatic logic atr_ok(input logic [7:0] flip);
      logic [7:0] x;
      x = flip;
      for (int i = 1; i < got.size(); i++) begin
         x ^= got[i];
      end
      atr_ok = (x == 8'h00);
   endfunction

   // next class: one step up on silence or a third bad answer
   function automatic logic [4:0] retry(input logic [4:0] c, input logic heard, input int bad);
      retry = c;
      if (!heard) begin
         retry = {1'b0, c[4:1]};
      end else if (bad >= 3) begin
         retry = {1'b0, c[4:1]};
      end
   endfunction
endmodule

/* card_supply_class_selector_bench.sv */
// Purpose: self-checking bench of the card core with a terminal model
// Assumes: HIST_LEN 4, historical byte n is A0+n
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/100ps

`define CHK(a, e) begin \
   cmp_count++; \
   if ((a) !== (e)) begin \
      mismatches++; \
      $display("unexpected at %0t: got %h want %h", $time, a, e); \
   end \
end

module card_supply_class_selector_bench;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic card_rst_n = 1'b0;
   logic [4:0] class_support = 5'h03;
   logic [1:0] clk_stop_ind = 2'h1;
   logic [7:0] global_tb = 8'h80;
   logic [3:0] hist_addr;
   logic [7:0] out_data;
   logic out_valid;
   logic out_ready;
   logic [7:0] resp_data = 8'h00;
   logic resp_valid = 1'b0;
   logic resp_ready;
   logic atr_done;
   logic class_trimmed;
   logic [2:0] evt = 3'h0;
   logic ac_required = 1'b0;
   logic cmd_is_app = 1'b0;
   logic cmd_is_status = 1'b0;
   logic app_selected;
   logic slow = 1'b0;
   int mismatches = 0;
   int cmp_count = 0;

   csc_card_core #(.HIST_LEN(4), .CLASS_W(5)) csc_card_core_i (
      .core_clk(core_clk), .arst_n(arst_n), .card_rst_n(card_rst_n),
      .class_support(class_support), .clk_stop_ind(clk_stop_ind),
      .global_tb(global_tb), .hist_addr(hist_addr), .hist_byte({4'hA, hist_addr}),
      .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
      .resp_data(resp_data), .resp_valid(resp_valid), .resp_ready(resp_ready),
      .atr_done(atr_done), .class_trimmed(class_trimmed), .app_select(evt[0]),
      .ac_required(ac_required), .ac_verified(evt[1]), .cmd_done(evt[2]),
      .cmd_is_app(cmd_is_app), .cmd_is_status(cmd_is_status),
      .app_selected(app_selected)
   );

   csc_term_model csc_term_model_i (
      .core_clk(core_clk), .slow(slow), .out_data(out_data),
      .out_valid(out_valid), .out_ready(out_ready)
   );

   initial begin
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================================
   // card reset, full answer, class choice
   task automatic run_atr(input logic [7:0] ta, input logic sl, input logic [4:0] cls);
      logic [7:0] exp [$];
      logic [7:0] x;
      int n;
      exp = '{8'h3B, 8'h84, 8'h80, 8'h3F, ta, global_tb, 8'hA0, 8'hA1, 8'hA2, 8'hA3};
      x = 8'h00;
      for (int i = 1; i < 10; i++) begin
         x ^= exp[i];
      end
      exp.push_back(x);
      slow = sl;
      card_rst_n = 1'b0;
      wait_clk(2);
      `CHK(out_valid, 1'b0)
      `CHK(app_selected, 1'b0)
      csc_term_model_i.got.delete();
      card_rst_n = 1'b1;
      wait_clk(1);
      `CHK(out_data, 8'h3B)
      `CHK(resp_ready, 1'b0)
      `CHK(atr_done, 1'b0)
      n = 0;
      while (atr_done !== 1'b1 && n < 200) begin
         wait_clk(1);
         n++;
      end
      if (n == 200) begin
         mismatches++;
         close_out();
      end
      `CHK(csc_term_model_i.got.size(), exp.size())
      foreach (exp[i]) begin
         `CHK(csc_term_model_i.got[i], exp[i])
      end
      `CHK(csc_term_model_i.pick(csc_term_model_i.got[4]), cls)
      $display("test answer %h done", ta);
   endtask

   task automatic run_resp;
      slow = 1'b0;
      resp_data = 8'h5A;
      resp_valid = 1'b1;
      for (int n = 0; n < 20 && resp_ready !== 1'b1; n++) begin
         wait_clk(1);
      end
      if (resp_ready !== 1'b1) begin
         mismatches++;
         close_out();
      end
      wait_clk(1);
      resp_valid = 1'b0;
      `CHK(out_valid, 1'b1)
      wait_clk(3);
      `CHK(csc_term_model_i.got[csc_term_model_i.got.size() - 1], 8'h5A)
      $display("test response done");
   endtask

   task automatic pulse(input logic [2:0] v, input logic want);
      evt = v;
      wait_clk(1);
      evt = 3'h0;
      wait_clk(1);
      `CHK(app_selected, want)
   endtask

   task automatic run_app;
      ac_required = 1'b1;
      cmd_is_app = 1'b1;
      pulse(3'h1, 1'b0);
      pulse(3'h4, 1'b0);
      pulse(3'h2, 1'b1);
      pulse(3'h1, 1'b0);
      ac_required = 1'b0;
      cmd_is_status = 1'b1;
      pulse(3'h4, 1'b0);
      cmd_is_status = 1'b0;
      pulse(3'h4, 1'b1);
      $display("test application done");
   endtask

   // ==========================================================
   // terminal class retries and answer integrity
   task automatic run_retry;
      int bad;
      logic [4:0] cls;
      cls = 5'h04;
      bad = 0;
      `CHK(csc_term_model_i.atr_ok(8'h00), 1'b1)
      `CHK(csc_term_model_i.atr_ok(8'h10), 1'b0)
      `CHK(csc_term_model_i.retry(cls, 1'b0, bad), 5'h02)
      for (int i = 0; i < 3; i++) begin
         `CHK(csc_term_model_i.retry(cls, 1'b1, bad), cls)
         bad++;
      end
      `CHK(csc_term_model_i.retry(cls, 1'b1, bad), 5'h02)
      cls = csc_term_model_i.retry(cls, 1'b1, bad);
      bad = 0;
      `CHK(csc_term_model_i.retry(cls, 1'b1, bad), 5'h02)
      $display("test retry done");
   endtask

   initial begin
      wait_clk(10);
      arst_n = 1'b1;
      wait_clk(1);
      run_atr(8'h43, 1'b1, 5'h02);
      `CHK(class_trimmed, 1'b0)
      run_resp();
      run_app();
      class_support = 5'h05;
      run_atr(8'h41, 1'b0, 5'h01);
      `CHK(class_trimmed, 1'b1)
      class_support = 5'h1C;
      clk_stop_ind = 2'h2;
      run_atr(8'h9C, 1'b1, 5'h04);
      `CHK(class_trimmed, 1'b0)
      run_retry();
      close_out();
   end
endmodule
